/* rtl/lmcc_pkg.sv */
// lmcc_pkg: register map, field layout and divider codes of the lcd mode/clock block
// assumes a byte-wide register port addressed by full 32-bit offsets
package lmcc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_MODE_ZERO = 32'h4004_9040;
  localparam logic [31:0] ADDR_MODE_ONE  = 32'h4004_9041;
  localparam logic [31:0] ADDR_CLK_DIV   = 32'h4004_9042;
  localparam logic [31:0] ADDR_CLK_SUPP  = 32'h4004_9048;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MODE_ZERO  = 8'h00;
  localparam logic [7:0] RST_MODE_ONE   = 8'h00;
  localparam logic [7:0] RST_CLK_DIV    = 8'h00;
  localparam logic [7:0] RST_CLK_SUPP   = 8'h00;
  localparam logic [7:0] MASK_MODE_ONE  = 8'hF9;
  localparam logic [7:0] MASK_CLK_DIV   = 8'h3F;
  localparam logic [7:0] MASK_CLK_SUPP  = 8'h03;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       display_on_bit;
    logic       output_gate_bit;
    logic       voltage_circuit_enable;
    logic       blink_bit;
    logic       data_area_select;
    logic [1:0] zero_bits;
    logic       boost_initial_level;
  } lmcc_mode_one_s;

  typedef struct packed {
    logic [1:0] drive_method;
    logic       waveform_b;
    logic [2:0] time_slice;
    logic [1:0] bias;
  } lmcc_mode_zero_s;

  // ----------------------------------------------------------------
  // divider and timing constants
  // ----------------------------------------------------------------
  localparam int          DIV_WIDTH    = 20;
  localparam logic [5:0]  CODE_SUB_LO  = 6'h04;
  localparam logic [5:0]  CODE_SUB_HI  = 6'h09;
  localparam logic [5:0]  CODE_MAIN_LO = 6'h13;
  localparam logic [5:0]  CODE_MAIN_HI = 6'h1B;
  localparam logic [5:0]  CODE_MAIN_19 = 6'h2B;
  localparam logic [4:0]  POW_SUB_BASE = 5'h05;
  localparam logic [4:0]  POW_MAIN_BASE = 5'h0A;
  localparam logic [4:0]  POW_MAIN_19  = 5'h13;
  localparam logic [1:0]  METHOD_EXT_RES = 2'h2;

endpackage : lmcc_pkg

/* rtl/lmcc_divider.sv */
// lmcc_divider: free-running binary divider with power-of-two tap select
// assumes src_en is a one-cycle enable per edge of the chosen source clock
`timescale 1ns/1ps
module lmcc_divider
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       src_en,
  input  wire logic [4:0] power,
  input  wire logic       valid,
  output logic            tick
);

  logic [lmcc_pkg::DIV_WIDTH-1:0] count_reg;
  logic [lmcc_pkg::DIV_WIDTH-1:0] tap_mask;

  // counter never resets on tap change, so the first period after a switch is short
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= '0;
    else if (src_en)
      count_reg <= count_reg + 1'b1;
  end

  assign tap_mask = lmcc_pkg::DIV_WIDTH'((21'h00_0001 << power) - 21'h00_0001);
  assign tick = valid && src_en && ((count_reg & tap_mask) == tap_mask);

endmodule : lmcc_divider

/* rtl/lmcc_top.sv */
// lmcc_top: lcd mode and clock control registers, output gating, blink and frame timing
// assumes the register master and rtc tick run on MCLK; clock pins are asynchronous
//
// Function
// - mode register one, eight bits, resets zero
// - gate bit low grounds all outputs
// - gate high: display bit picks off or on
// - voltage enable bit starts or stops pump
// - no blink: select picks low/high nibble
// - blink toggles nibble on rtc tick
// - boost level bit sets initial pin level
// - gate high freezes pump and boost bits
// - clock divider register, six bits, resets zero
// - sub clock divided 2^5 to 2^10, low-speed 2^5 to 2^9
// - main clock divided 2^10 to 2^19
// - divider register locked while gate high
// - frame period from clock and slices
// - gating bit keeps sub/low-speed panel clock in sleep
// - slice field codes static to eight
// - mode register zero locked while gate high
`timescale 1ns/1ps
module lmcc_top
(
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic [31:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic        FSUB_CLK,
  input  wire logic        FIL_CLK,
  input  wire logic        RTC_TICK,
  output logic             OUT_GROUND,
  output logic             OUT_NONSELECT,
  output logic             DISPLAY_ACTIVE,
  output logic             PUMP_ENABLE,
  output logic             BOOST_INIT_LEVEL,
  output logic             NIBBLE_HIGH,
  output logic      [2:0]  SLICE,
  output logic             FRAME_START,
  output logic             PANEL_TICK,
  output logic             KEEP_CLOCK_IN_SLEEP
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  lmcc_pkg::lmcc_mode_one_s  mode_one_reg;
  lmcc_pkg::lmcc_mode_zero_s mode_zero_reg;
  logic [5:0]                clk_div_reg;
  logic [1:0]                clk_supp_reg;
  logic [7:0]                rdata_reg;
  logic [7:0]                rdata_next;
  logic                      locked;
  logic                      wr_one;
  logic                      wr_zero;
  logic                      wr_div;
  logic                      wr_supp;

  assign locked  = mode_one_reg.output_gate_bit;
  assign wr_one  = WR && (ADDR == lmcc_pkg::ADDR_MODE_ONE);
  assign wr_zero = WR && (ADDR == lmcc_pkg::ADDR_MODE_ZERO);
  assign wr_div  = WR && (ADDR == lmcc_pkg::ADDR_CLK_DIV);
  assign wr_supp = WR && (ADDR == lmcc_pkg::ADDR_CLK_SUPP);

  // pump and boost bits keep their value while the gate bit is high
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      mode_one_reg <= lmcc_pkg::RST_MODE_ONE;
    else if (wr_one)
    begin
      mode_one_reg.display_on_bit   <= WDATA[7];
      mode_one_reg.output_gate_bit  <= WDATA[6];
      mode_one_reg.blink_bit        <= WDATA[4];
      mode_one_reg.data_area_select <= WDATA[3];
      mode_one_reg.zero_bits        <= 2'h0;
      if (!locked)
      begin
        mode_one_reg.voltage_circuit_enable <= WDATA[5];
        mode_one_reg.boost_initial_level    <= WDATA[0];
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      mode_zero_reg <= lmcc_pkg::RST_MODE_ZERO;
    else if (wr_zero && !locked)
      mode_zero_reg <= WDATA;
  end

  // upper bits are dropped, so stray ones written to bits 7:6 read back as zero
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      clk_div_reg <= lmcc_pkg::RST_CLK_DIV[5:0];
    else if (wr_div && !locked)
      clk_div_reg <= WDATA[5:0];
  end

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      clk_supp_reg <= lmcc_pkg::RST_CLK_SUPP[1:0];
    else if (wr_supp && !locked)
      clk_supp_reg <= WDATA[1:0];
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_next = 8'h00;
    unique case (ADDR)
      lmcc_pkg::ADDR_MODE_ONE:  rdata_next = mode_one_reg & lmcc_pkg::MASK_MODE_ONE;
      lmcc_pkg::ADDR_MODE_ZERO: rdata_next = mode_zero_reg;
      lmcc_pkg::ADDR_CLK_DIV:   rdata_next = {2'h0, clk_div_reg};
      lmcc_pkg::ADDR_CLK_SUPP:  rdata_next = {6'h00, clk_supp_reg};
      default:                  rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      rdata_reg <= 8'h00;
    else if (RD)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= 8'h00;
  end

  assign RDATA = rdata_reg;

  // ----------------------------------------------------------------
  // source clock synchronisers and edge enables
  // ----------------------------------------------------------------
  logic [2:0] sub_sync_reg;
  logic [2:0] fil_sync_reg;
  logic       sub_en;
  logic       fil_en;

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sub_sync_reg <= 3'h0;
      fil_sync_reg <= 3'h0;
    end
    else
    begin
      sub_sync_reg <= {sub_sync_reg[1:0], FSUB_CLK};
      fil_sync_reg <= {fil_sync_reg[1:0], FIL_CLK};
    end
  end

  assign sub_en = sub_sync_reg[1] && !sub_sync_reg[2];
  assign fil_en = fil_sync_reg[1] && !fil_sync_reg[2];

  // ----------------------------------------------------------------
  // divider code decode
  // ----------------------------------------------------------------
  // returns {valid, from_main, power}
  function automatic logic [6:0] lmcc_decode(input logic [5:0] code, input logic use_fil);
    logic [6:0] res;
    res = 7'h00;
    if (code >= lmcc_pkg::CODE_SUB_LO && code <= lmcc_pkg::CODE_SUB_HI)
    begin
      res = {1'b1, 1'b0, 5'(lmcc_pkg::POW_SUB_BASE + 5'(code - lmcc_pkg::CODE_SUB_LO))};
      if (use_fil && code == lmcc_pkg::CODE_SUB_HI)
        res = 7'h00;
    end
    else if (code >= lmcc_pkg::CODE_MAIN_LO && code <= lmcc_pkg::CODE_MAIN_HI)
      res = {1'b1, 1'b1, 5'(lmcc_pkg::POW_MAIN_BASE + 5'(code - lmcc_pkg::CODE_MAIN_LO))};
    else if (code == lmcc_pkg::CODE_MAIN_19)
      res = {1'b1, 1'b1, lmcc_pkg::POW_MAIN_19};
    return res;
  endfunction : lmcc_decode

  logic [6:0] dec;
  logic       src_en;
  logic       panel_tick;

  assign dec    = lmcc_decode(clk_div_reg, clk_supp_reg[0]);
  // main clock is MCLK itself: every cycle is a source edge
  assign src_en = dec[5] ? 1'b1 : (clk_supp_reg[0] ? fil_en : sub_en);

  lmcc_divider u_divider
  (
    .clk    (MCLK),
    .rst_n  (RESETN),
    .src_en (src_en),
    .power  (dec[4:0]),
    .valid  (dec[6]),
    .tick   (panel_tick)
  );

  // ----------------------------------------------------------------
  // slice and frame sequencing
  // ----------------------------------------------------------------
  function automatic logic [2:0] lmcc_last_slice(input logic [2:0] code);
    unique case (code)
      3'h0:    return 3'h0;
      3'h1:    return 3'h1;
      3'h2:    return 3'h2;
      3'h3:    return 3'h3;
      3'h4:    return 3'h5;
      3'h5:    return 3'h7;
      default: return 3'h0;
    endcase
  endfunction : lmcc_last_slice

  logic [2:0] slice_reg;
  logic [2:0] last_slice;
  logic       frame_reg;
  logic       tick_reg;

  assign last_slice = lmcc_last_slice(mode_zero_reg.time_slice);

  // sequencing is held at slice zero while outputs are grounded
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      slice_reg <= 3'h0;
    else if (!locked)
      slice_reg <= 3'h0;
    else if (panel_tick)
      slice_reg <= (slice_reg >= last_slice) ? 3'h0 : slice_reg + 3'h1;
  end

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      frame_reg <= 1'b0;
      tick_reg  <= 1'b0;
    end
    else
    begin
      frame_reg <= locked && panel_tick && (slice_reg >= last_slice);
      tick_reg  <= panel_tick;
    end
  end

  // ----------------------------------------------------------------
  // nibble select and blink
  // ----------------------------------------------------------------
  logic nibble_reg;

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      nibble_reg <= 1'b0;
    else if (!mode_one_reg.blink_bit)
      nibble_reg <= mode_one_reg.data_area_select;
    else if (RTC_TICK)
      nibble_reg <= !nibble_reg;
  end

  // ----------------------------------------------------------------
  // output gating and analog controls
  // ----------------------------------------------------------------
  logic ground_reg;
  logic nonsel_reg;
  logic active_reg;
  logic pump_reg;
  logic boost_reg;
  logic keep_reg;

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ground_reg <= 1'b1;
      nonsel_reg <= 1'b0;
      active_reg <= 1'b0;
    end
    else
    begin
      ground_reg <= !mode_one_reg.output_gate_bit;
      nonsel_reg <= mode_one_reg.output_gate_bit && !mode_one_reg.display_on_bit;
      active_reg <= mode_one_reg.output_gate_bit && mode_one_reg.display_on_bit;
    end
  end

  // a pump enable under external resistor drive is software's fault; it is passed as written
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      pump_reg  <= 1'b0;
      boost_reg <= 1'b0;
      keep_reg  <= 1'b0;
    end
    else
    begin
      pump_reg  <= mode_one_reg.voltage_circuit_enable;
      boost_reg <= mode_one_reg.boost_initial_level;
      keep_reg  <= clk_supp_reg[1] && !dec[5];
    end
  end

  assign OUT_GROUND          = ground_reg;
  assign OUT_NONSELECT       = nonsel_reg;
  assign DISPLAY_ACTIVE      = active_reg;
  assign PUMP_ENABLE         = pump_reg;
  assign BOOST_INIT_LEVEL    = boost_reg;
  assign NIBBLE_HIGH         = nibble_reg;
  assign SLICE               = slice_reg;
  assign FRAME_START         = frame_reg;
  assign PANEL_TICK          = tick_reg;
  assign KEEP_CLOCK_IN_SLEEP = keep_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  ground_out_a: assert property ($past(!locked) |-> OUT_GROUND && !DISPLAY_ACTIVE)
    else $error("outputs not grounded with gate low");
  nonsel_out_a: assert property ($past(locked && !mode_one_reg.display_on_bit) |->
    OUT_NONSELECT && !OUT_GROUND)
    else $error("display off not non-select");
  pump_follow_a: assert property (##1 PUMP_ENABLE == $past(mode_one_reg.voltage_circuit_enable))
    else $error("pump enable does not follow bit");
  bits_frozen_a: assert property (locked && wr_one |=>
    $stable(mode_one_reg.voltage_circuit_enable) && $stable(mode_one_reg.boost_initial_level))
    else $error("pump or boost bit changed while gated");
  div_locked_a: assert property (locked |=> $stable(clk_div_reg))
    else $error("divider register changed while gated");
  mode0_locked_a: assert property (locked |=> $stable(mode_zero_reg))
    else $error("mode zero changed while gated");
  nibble_sel_a: assert property ($past(!mode_one_reg.blink_bit) |->
    NIBBLE_HIGH == $past(mode_one_reg.data_area_select))
    else $error("nibble does not match select");
  blink_flip_a: assert property (mode_one_reg.blink_bit && RTC_TICK |=>
    NIBBLE_HIGH != $past(NIBBLE_HIGH))
    else $error("blink did not toggle on rtc tick");
  slice_range_a: assert property (locked |-> slice_reg <= last_slice || $changed(last_slice))
    else $error("slice beyond configured count");
  div_read_a: assert property (RD && ADDR == lmcc_pkg::ADDR_CLK_DIV |=>
    RDATA[7:6] == 2'h0 && RDATA[5:0] == $past(clk_div_reg))
    else $error("divider readback wrong");

  blink_cov_c:  cover property (mode_one_reg.blink_bit && RTC_TICK ##1 NIBBLE_HIGH);
  frame_cov_c:  cover property (FRAME_START && last_slice == 3'h7);
  locked_cov_c: cover property (locked && wr_div);

endmodule : lmcc_top

/* testbench/lmcc_panel_model.sv */
// lmcc_panel_model: far side of the block, the panel and its clock sources
// assumes the display state outputs are one-hot levels in the MCLK domain
`timescale 1ns/1ps
module lmcc_panel_model
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic out_ground,
  input  wire logic out_nonselect,
  input  wire logic display_active,
  output logic      fsub_clk,
  output logic      fil_clk,
  output logic      state_fault
);
  // ----------------------------------------------------------------
  // oscillators: free running, exactly 8 and 12 MCLK periods
  // ----------------------------------------------------------------
  initial
  begin
    fsub_clk = 1'b0;
    #7;
    forever #160 fsub_clk = ~fsub_clk;
  end

  initial
  begin
    fil_clk = 1'b0;
    #13;
    forever #240 fil_clk = ~fil_clk;
  end

  // ----------------------------------------------------------------
  // panel sees exactly one of ground, non-select or driven
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state_fault <= 1'b0;
    else if ($onehot({out_ground, out_nonselect, display_active}) !== 1'b1)
      state_fault <= 1'b1;
  end
endmodule : lmcc_panel_model

/* testbench/lcd_mode_and_clock_control_tb.sv */
// lcd_mode_and_clock_control_tb: register-level tests of the lcd mode/clock block
// assumes the panel model supplies both slow clocks; main clock is MCLK
`timescale 1ns/1ps
module lcd_mode_and_clock_control_tb;
  logic        MCLK = 1'b0;
  logic        RESETN = 1'b0;
  logic [31:0] ADDR = 32'h0000_0000;
  logic [7:0]  WDATA = 8'h00;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        RTC_TICK = 1'b0;
  logic [7:0]  RDATA;
  logic        FSUB_CLK, FIL_CLK, FAULT;
  logic        GND, NONSEL, ACT, PUMP, BOOST, NIB, FRM, TICK, KEEP;
  logic [2:0]  SLICE;
  int          err_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          g;
  logic [7:0]  gate_code [4] = '{8'h00, 8'h80, 8'h40, 8'hC0};
  logic [2:0]  gate_exp [4] = '{3'h4, 3'h4, 3'h2, 3'h1};

  always #20 MCLK = ~MCLK;

  lmcc_top i_dut (.MCLK(MCLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .FSUB_CLK(FSUB_CLK), .FIL_CLK(FIL_CLK), .RTC_TICK(RTC_TICK),
    .OUT_GROUND(GND), .OUT_NONSELECT(NONSEL), .DISPLAY_ACTIVE(ACT), .PUMP_ENABLE(PUMP),
    .BOOST_INIT_LEVEL(BOOST), .NIBBLE_HIGH(NIB), .SLICE(SLICE), .FRAME_START(FRM),
    .PANEL_TICK(TICK), .KEEP_CLOCK_IN_SLEEP(KEEP));

  lmcc_panel_model i_panel (.mclk(MCLK), .rst_n(RESETN), .out_ground(GND),
    .out_nonselect(NONSEL), .display_active(ACT), .fsub_clk(FSUB_CLK), .fil_clk(FIL_CLK),
    .state_fault(FAULT));

  // ----------------------------------------------------------------
  // bus, compare and timing helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge MCLK);
    WR    <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp);
    @(posedge MCLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge MCLK);
    RD   <= 1'b0;
    @(posedge MCLK);
    chk(RDATA, exp, "read data");
  endtask : rd_chk

  task automatic settle();
    repeat (2) @(posedge MCLK);
  endtask : settle

  task automatic rtc_pulse();
    @(posedge MCLK);
    RTC_TICK <= 1'b1;
    @(posedge MCLK);
    RTC_TICK <= 1'b0;
    settle();
  endtask : rtc_pulse

  function automatic logic pulse(input bit sel);
    return sel ? FRM : TICK;
  endfunction : pulse

  // cycles between two consecutive pulses, bounded so a dead divider cannot hang
  task automatic gap_of(input bit sel, output int n);
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(posedge MCLK);
        n++;
      end while (pulse(sel) !== 1'b1 && n < 20000);
    end
  endtask : gap_of

  task automatic no_ticks();
    int c;
    c = 0;
    settle();
    repeat (3000)
    begin
      @(posedge MCLK);
      if (TICK !== 1'b0) c++;
    end
    chk(c, 0, "ticks on a refused code");
  endtask : no_ticks

  always @(posedge MCLK)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      err_count++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge MCLK);
    RESETN <= 1'b1;
    chk(GND, 1'b1, "ground after reset");
    rd_chk(lmcc_pkg::ADDR_MODE_ONE, 8'h00);
    rd_chk(lmcc_pkg::ADDR_CLK_DIV, 8'h00);
    rd_chk(32'h4004_9044, 8'h00);
    $display("test reset done");

    // drive method stays internal boost, so boost level one is allowed
    wr_reg(lmcc_pkg::ADDR_MODE_ONE, 8'h07);
    rd_chk(lmcc_pkg::ADDR_MODE_ONE, 8'h01);
    chk(BOOST, 1'b1, "boost level");
    // capacitor split: boost level cleared first, no reference wait needed before the pump
    wr_reg(lmcc_pkg::ADDR_MODE_ONE, 8'h00);
    wr_reg(lmcc_pkg::ADDR_MODE_ZERO, 8'h40);
    wr_reg(lmcc_pkg::ADDR_MODE_ONE, 8'h20);
    settle();
    chk({PUMP, BOOST}, 2'h2, "pump run");
    wr_reg(lmcc_pkg::ADDR_MODE_ONE, 8'h08);
    wr_reg(lmcc_pkg::ADDR_MODE_ZERO, 8'h00);
    settle();
    chk({PUMP, NIB}, 2'h1, "upper nibble");
    wr_reg(lmcc_pkg::ADDR_MODE_ONE, 8'h00);
    settle();
    chk(NIB, 1'b0, "lower nibble");
    wr_reg(lmcc_pkg::ADDR_MODE_ONE, 8'h10);
    rtc_pulse();
    chk(NIB, 1'b1, "blink first tick");
    rtc_pulse();
    chk(NIB, 1'b0, "blink second tick");
    $display("test fields done");

    for (int i = 0; i < 4; i++)
    begin
      wr_reg(lmcc_pkg::ADDR_MODE_ONE, gate_code[i]);
      settle();
      chk({GND, NONSEL, ACT}, gate_exp[i], "display gating");
    end
    $display("test gating done");

    wr_reg(lmcc_pkg::ADDR_MODE_ONE, 8'hE1);
    rd_chk(lmcc_pkg::ADDR_MODE_ONE, 8'hC0);
    chk({PUMP, BOOST}, 2'h0, "frozen pump and boost");
    wr_reg(lmcc_pkg::ADDR_CLK_DIV, 8'h13);
    rd_chk(lmcc_pkg::ADDR_CLK_DIV, 8'h00);
    wr_reg(lmcc_pkg::ADDR_MODE_ZERO, 8'h0C);
    rd_chk(lmcc_pkg::ADDR_MODE_ZERO, 8'h00);
    wr_reg(lmcc_pkg::ADDR_MODE_ONE, 8'h00);
    $display("test lock done");

    wr_reg(lmcc_pkg::ADDR_CLK_DIV, 8'h3F);
    rd_chk(lmcc_pkg::ADDR_CLK_DIV, 8'h3F);
    wr_reg(lmcc_pkg::ADDR_CLK_DIV, 8'h00);
    no_ticks();
    wr_reg(lmcc_pkg::ADDR_CLK_DIV, 8'h13);
    gap_of(1'b0, g);
    chk(g, 1024, "main clock over 2^10");
    wr_reg(lmcc_pkg::ADDR_CLK_DIV, 8'h14);
    gap_of(1'b0, g);
    chk(g, 2048, "main clock over 2^11");
    wr_reg(lmcc_pkg::ADDR_CLK_SUPP, 8'h02);
    settle();
    chk(KEEP, 1'b0, "main source not kept");
    wr_reg(lmcc_pkg::ADDR_CLK_DIV, 8'h04);
    gap_of(1'b0, g);
    chk(g, 256, "subsystem over 2^5");
    chk(KEEP, 1'b1, "sub source kept in sleep");
    // blink is already clear before the low-speed source is picked
    wr_reg(lmcc_pkg::ADDR_CLK_SUPP, 8'h03);
    wr_reg(lmcc_pkg::ADDR_CLK_DIV, 8'h05);
    gap_of(1'b0, g);
    chk(g, 768, "low-speed over 2^6");
    wr_reg(lmcc_pkg::ADDR_CLK_DIV, 8'h09);
    no_ticks();
    $display("test divider done");

    wr_reg(lmcc_pkg::ADDR_CLK_SUPP, 8'h00);
    wr_reg(lmcc_pkg::ADDR_CLK_DIV, 8'h13);
    wr_reg(lmcc_pkg::ADDR_MODE_ZERO, 8'h0C);
    wr_reg(lmcc_pkg::ADDR_MODE_ONE, 8'h40);
    gap_of(1'b1, g);
    chk(g, 4096, "four slice frame");
    wr_reg(lmcc_pkg::ADDR_MODE_ONE, 8'h00);
    wr_reg(lmcc_pkg::ADDR_MODE_ZERO, 8'h14);
    wr_reg(lmcc_pkg::ADDR_MODE_ONE, 8'h40);
    gap_of(1'b1, g);
    chk(g, 8192, "eight slice frame");
    gap_of(1'b0, g);
    chk(SLICE, 3'h2, "slice index two ticks after wrap");
    rd_chk(lmcc_pkg::ADDR_MODE_ZERO, 8'h14);
    wr_reg(lmcc_pkg::ADDR_MODE_ONE, 8'h00);
    wr_reg(lmcc_pkg::ADDR_MODE_ZERO, 8'h00);
    settle();
    chk({GND, PUMP}, 2'h2, "idle display");
    chk(FAULT, 1'b0, "panel state one-hot");
    $display("test frames done");
    results();
  end
endmodule : lcd_mode_and_clock_control_tb
